// >>> hw/hirq_latches.sv
// Host interrupt request latches in port four data register bits 3..5
//
// How it works
// - With host_if_enable high, port bits 3..5 act as host irq latches.
// - Chan2 latch sets on firmware read-0-then-write-1, clears on 0 write or out_data_reg_two read.
// - Primary latch sets on read-0-then-write-1, clears on 0 write or out_data_reg_one read.
// - Aux latch sets on read-0-then-write-1, clears on 0 write or out_data_reg_one read.
// - Chip select one low, address low and a falling read strobe clear primary and aux.
// - Chip select two low, address low and a falling read strobe clear chan2.
// - Host and firmware must handshake so they never touch one data register at once.
// - A chip select two read returns out_data_reg_two at address 0, status_reg_two at 1.
`timescale 1ns/1ns
`include "hirq_defines.svh"
module hirq_latches (
   input  wire logic                  clk,
   input  wire logic                  arst_n,
   input  wire logic                  host_if_enable,
   input  wire logic                  fw_rd,
   input  wire logic                  fw_wr,
   input  wire logic [7:0]            fw_wdata,
   output logic      [7:0]            port_four_data_reg,
   input  wire hirq_pkg::hirq_host_bus_s host_bus,
   input  wire logic [7:0]            out_data_reg_two,
   input  wire logic [7:0]            status_reg_two,
   output logic      [7:0]            host_rdata,
   output logic      [2:0]            host_irq_pins
);
   // Host pins are asynchronous: two flops before any use
   hirq_pkg::hirq_host_bus_s s1_q, s2_q, s3_q;
   hirq_pkg::hirq_latch_s    lat_q, lat_d, armed_q, armed_d;
   logic [7:0]               port_q, port_d, rdata_q, rdata_d;
   logic [2:0]               pins_q, pins_d;
   logic                     rd_fall, clr_one, clr_two;

   function automatic logic latch_next(input logic cur, input logic armed,
                                       input logic wr, input logic wbit,
                                       input logic host_clr);
      logic n;
      n = cur;
      if (wr && !wbit)
         n = 1'b0;
      else if (wr && wbit && armed)
         n = 1'b1;
      // Firmware set wins over a simultaneous host clear
      if (host_clr && !(wr && wbit && armed))
         n = 1'b0;
      return n;
   endfunction

   always_comb begin
      rd_fall = s3_q.rd_n && !s2_q.rd_n;
      clr_one = rd_fall && !s2_q.cs1_n && !s2_q.addr && host_if_enable;
      clr_two = rd_fall && !s2_q.cs2_n && !s2_q.addr && host_if_enable;

      // Read-0 arms the set; a write without a read in the same cycle disarms
      armed_d = armed_q;
      if (fw_rd) begin
         armed_d.chan2   = !lat_q.chan2;
         armed_d.primary = !lat_q.primary;
         armed_d.aux     = !lat_q.aux;
      end else if (fw_wr) begin
         armed_d = '0;
      end

      lat_d.chan2   = latch_next(lat_q.chan2, armed_q.chan2, fw_wr,
                         fw_wdata[`HIRQ_BIT_CHAN2], clr_two);
      lat_d.primary = latch_next(lat_q.primary, armed_q.primary, fw_wr,
                         fw_wdata[`HIRQ_BIT_PRIMARY], clr_one);
      lat_d.aux     = latch_next(lat_q.aux, armed_q.aux, fw_wr,
                         fw_wdata[`HIRQ_BIT_AUX], clr_one);

      port_d = port_q;
      if (fw_wr)
         port_d = fw_wdata;
      port_d[`HIRQ_BIT_CHAN2]   = lat_d.chan2;
      port_d[`HIRQ_BIT_PRIMARY] = lat_d.primary;
      port_d[`HIRQ_BIT_AUX]     = lat_d.aux;

      // Latches reach the pins only in slave mode
      pins_d = host_if_enable ? {lat_d.aux, lat_d.primary, lat_d.chan2}
                              : 3'h0;

      rdata_d = rdata_q;
      if (!s2_q.cs2_n && !s2_q.rd_n)
         rdata_d = s2_q.addr ? status_reg_two : out_data_reg_two;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q    <= '1;
         s2_q    <= '1;
         s3_q    <= '1;
         lat_q   <= `HIRQ_LATCH_RESET;
         armed_q <= '0;
         port_q  <= `HIRQ_PORT_RESET;
         pins_q  <= `HIRQ_LATCH_RESET;
         rdata_q <= 8'h00;
      end else begin
         s1_q    <= host_bus;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         lat_q   <= lat_d;
         armed_q <= armed_d;
         port_q  <= port_d;
         pins_q  <= pins_d;
         rdata_q <= rdata_d;
      end
   end

   assign port_four_data_reg = port_q;
   assign host_irq_pins      = pins_q;
   assign host_rdata         = rdata_q;
endmodule

// >>> common/hirq_defines.svh
// Bit positions and reset values for the host interrupt latches
`ifndef HIRQ_DEFINES_SVH
`define HIRQ_DEFINES_SVH
`define HIRQ_BIT_CHAN2   3
`define HIRQ_BIT_PRIMARY 4
`define HIRQ_BIT_AUX     5
`define HIRQ_PORT_RESET  8'h00
`define HIRQ_LATCH_RESET 3'h0
`endif

// >>> common/hirq_pkg.sv
// Types shared by the host interrupt latch block
package hirq_pkg;
   typedef struct packed {
      logic       cs1_n;
      logic       cs2_n;
      logic       addr;
      logic       rd_n;
   } hirq_host_bus_s;

   typedef struct packed {
      logic       aux;
      logic       primary;
      logic       chan2;
   } hirq_latch_s;

   typedef enum logic [1:0] {
      HIRQ_SEL_ODR  = 2'b01,
      HIRQ_SEL_STAT = 2'b10
   } hirq_rdsel_e;
endpackage

// >>> test/hirq_latches_props.sv
// Port assertions for the host interrupt latches
`timescale 1ns/1ns
module hirq_latches_props (
   input wire logic                     clk,
   input wire logic                     arst_n,
   input wire logic                     host_if_enable,
   input wire logic                     fw_rd,
   input wire logic                     fw_wr,
   input wire logic [7:0]               fw_wdata,
   input wire logic [7:0]               port_four_data_reg,
   input wire logic [7:0]               status_reg_two,
   input wire logic [7:0]               host_rdata,
   input wire logic [2:0]               host_irq_pins,
   input wire hirq_pkg::hirq_host_bus_s host_bus
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire e = host_if_enable, r = host_bus.rd_n, a = host_bus.addr;
   wire c1 = !host_bus.cs1_n, c2 = !host_bus.cs2_n;
   wire [7:0] p = port_four_data_reg;
   wire [2:0] q = host_irq_pins;
   logic [7:0] z;
   always_ff @(posedge clk) z <= {8{fw_rd}} & ~p;
   wire [7:0] s = {8{fw_wr}} & fw_wdata & z;
   a_pins_off: assert property (!e |=> !q) else $error("pins on");
   a_chan2_set: assert property (s[3] |=> p[3]) else $error("no set");
   a_prim_set: assert property (s[4] && e |=> q[1]) else $error("no set");
   a_aux_wr0: assert property (fw_wr && !fw_wdata[5] |=> !p[5])
      else $error("aux kept");
   a_out_data_reg_one_clr: assert property ($fell(r) && c1 && !a && e
      |-> ##[1:5] !q[2:1]) else $error("out_data_reg_one read kept latch");
   a_out_data_reg_two_clr: assert property ($fell(r) && c2 && !a && e
      |-> ##[1:5] !q[0]) else $error("out_data_reg_two read kept latch");
   a_stat_read: assert property ($fell(r) && c2 && a && e
      |-> ##[1:5] host_rdata == status_reg_two) else $error("bad status");
   a_reset_clr: assert property ($rose(arst_n) |-> !p[5:3] && !q)
      else $error("not clear");
endmodule
bind hirq_latches hirq_latches_props u_hirq_latches_props (.*);

// >>> test/hirq_host_mdl.sv
// Host bus model issuing chip-select reads
`timescale 1ns/1ns
module hirq_host_mdl (
   input wire logic                 clk,
   output hirq_pkg::hirq_host_bus_s bus
);
   initial bus = 4'hd;
   // Select held past the strobe so a synchronised sample still sees it
   task automatic rd(input logic c2, a);
      @(posedge clk) #1 bus = {c2, !c2, a, 1'b0};
      // Strobe low for four edges, then select for four more
      repeat (4) @(posedge clk);
      #1 bus.rd_n = 1'b1;
      repeat (4) @(posedge clk);
      #1 bus = 4'hd;
   endtask
endmodule

// >>> test/hirq_latches_tb.sv
// Self-checking bench for the host interrupt latches
`timescale 1ns/1ns
module hirq_latches_tb;
   logic clk = 0, arst_n = 0, host_if_enable = 1, fw_rd = 0, fw_wr = 0;
   logic [7:0] fw_wdata = 0, out_data_reg_two = 0, status_reg_two = 0;
   logic [7:0] port_four_data_reg, host_rdata, m = 0, x = 0;
   logic [2:0] host_irq_pins;
   logic [9:0] t[10] = '{10'h108, 10'h110, 10'h120, 10'h038, 10'h138,
      10'h200, 10'h203, 10'h201, 10'h202, 10'h1ff};
   hirq_pkg::hirq_host_bus_s host_bus;
   int fail_count = 0, cmp_count = 0;
   hirq_latches u_hirq_latches (.*);
   hirq_host_mdl u_hirq_host_mdl (.clk, .bus(host_bus));
   initial forever #25 clk = ~clk;
   initial begin #90000 fail_count++; tally_and_finish; end
   task chk(input logic [7:0] g, w);
      cmp_count++;
      if (g !== w) fail_count++;
      if (g !== w) $display("mismatch %0t got %h want %h", $time, g, w);
   endtask
   task step(input bit h, r, input logic [7:0] d);
      if (h) u_hirq_host_mdl.rd(d[0], d[1]);
      else begin
         @(posedge clk) #1 fw_rd = r;
         @(posedge clk) #1 {fw_rd, fw_wr, fw_wdata} = {2'b01, d};
         @(posedge clk) #1 fw_wr = 0;
      end
      for (int i = 3; i < 6; i++)
         if (h ? host_if_enable && !d[1] && d[0] == (i == 3)
               : !d[i] || r && !m[i]) m[i] = h ? 1'b0 : d[i];
      if (h && d[0]) x = d[1] ? status_reg_two : out_data_reg_two;
      @(posedge clk) #1 chk(port_four_data_reg & 8'h38, m);
      chk({5'h00, host_irq_pins}, host_if_enable ? m[5:3] : 8'h00);
      chk(host_rdata, x);
   endtask
   initial begin
      void'($urandom(32'h5770));
      {out_data_reg_two, status_reg_two} = 16'($urandom);
      repeat (2) @(posedge clk);
      #1 arst_n = 1;
      chk(port_four_data_reg, 8'h00);
      foreach (t[i]) step(t[i][9], t[i][8], t[i][7:0]);
      $display("fixed tests done");
      host_if_enable = 0;
      step(1, 0, 8'h01);
      host_if_enable = 1;
      repeat (40) step(1'($urandom), 1'($urandom), 8'($urandom));
      $display("random tests done");
      tally_and_finish;
   end
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
endmodule
